// ---- rtc_pkg.sv ----
// Shared constants, register map and carrier types of the periodic counter.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
`default_nettype none

package rtc_pkg;

	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Widths
	// ****************************************************************
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int PS_W   = 4;
	localparam int CLKS_W = 2;
	localparam int DIV_W  = 18;
	localparam int TAB_N  = 32;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_SC       = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_CNT      = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_MOD      = 3'h2;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 3'h3;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 3'h4;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 3'h5;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SC_FLAG_BIT   = 7;
	localparam int SC_CLKS_HI    = 6;
	localparam int SC_CLKS_LO    = 5;
	localparam int SC_IE_BIT     = 4;
	localparam int SC_PS_HI      = 3;
	localparam int SC_PS_LO      = 0;
	localparam int IRQ_MATCH_BIT = 0;

	// ****************************************************************
	// Reset values and codes
	// ****************************************************************
	localparam logic [DATA_W-1:0] CNT_RST   = 8'h00;
	localparam logic [DATA_W-1:0] MOD_RST   = 8'h00;
	localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
	localparam logic [PS_W-1:0]   PS_OFF    = 4'h0;
	localparam logic [CLKS_W-1:0] CLKS_LPO  = 2'h0;
	localparam logic [CLKS_W-1:0] CLKS_EXT  = 2'h1;
	localparam logic [DIV_W-1:0]  PRESC_RST = 18'h00000;
	localparam logic [DIV_W-1:0]  PRESC_ONE = 18'h00001;
	localparam logic [DATA_W-1:0] CNT_ONE   = 8'h01;

	// ****************************************************************
	// Divide ratio, indexed by {clock source bit 0, prescale select}.
	// ****************************************************************
	localparam logic [DIV_W-1:0] DIV_TABLE [TAB_N] = '{
		18'h00000, 18'h00008, 18'h00020, 18'h00040,
		18'h00080, 18'h00100, 18'h00200, 18'h00400,
		18'h00001, 18'h00002, 18'h00004, 18'h0000a,
		18'h00010, 18'h00064, 18'h001f4, 18'h003e8,
		18'h00000, 18'h00400, 18'h00800, 18'h01000,
		18'h02000, 18'h04000, 18'h08000, 18'h10000,
		18'h003e8, 18'h007d0, 18'h01388, 18'h02710,
		18'h04e20, 18'h0c350, 18'h186a0, 18'h30d40
	};

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic low_power_osc_clock;
		logic external_ref_clock;
		logic internal_ref_clock;
	} src_clks_t;

	typedef struct packed {
		logic [CLKS_W-1:0] clock_source_select;
		logic [PS_W-1:0]   prescale_select;
		logic              match_irq_enable;
		logic              match_flag;
		logic [DATA_W-1:0] modulo_value;
		logic [DATA_W-1:0] count_value;
		logic [DIV_W-1:0]  presc;
		logic [DATA_W-1:0] rdata;
	} rtc_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
	} sync_state_t;

endpackage

`default_nettype wire

// ---- clock_edge_sync.sv ----
// Brings one slow source clock into the system clock domain as a pulse.
// Assumes the source runs well below half the system clock rate.
`default_nettype none

module clock_edge_sync
	import rtc_pkg::*;
(
	// System
	input  wire logic clk,
	input  wire logic nrst,
	// Source pin
	input  wire logic src,
	// One-cycle pulse per filtered rising edge
	output var  logic rise
);

	timeunit 1ns;
	timeprecision 1ns;

	sync_state_t q;
	sync_state_t d;

	// A level change counts only once the second and third stages agree,
	// so a glitch caught by the first stage never produces an edge.
	always_comb begin
		d      = q;
		d.s1   = src;
		d.s2   = q.s1;
		d.s3   = q.s2;
		d.rise = 1'b0;
		if (q.s2 == q.s3 && q.s3 != q.level) begin
			d.level = q.s3;
			d.rise  = q.s3;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rise = q.rise;

endmodule

`default_nettype wire

// ---- periodic_realtime_counter.sv ----
// Periodic real-time counter with prescaler, modulo match and interrupt.
// Assumes a register master on clk and three slow source clocks on pins.
//
// Contract
// RQ1 - Eight-bit counter, eight-bit modulo, source selector, prescaler.
// RQ2 - Reset stops counter at 0x00, modulo 0x00, prescaler off.
// RQ3 - Reset selects the low-power oscillator as prescaler input.
// RQ4 - Prescale select zero keeps prescaler off; nonzero starts it.
// RQ5 - Source 00 low-power, 01 external, 1x internal reference clock.
// RQ6 - Writing a different source clears prescaler and counter.
// RQ7 - Writing a different prescale select clears prescaler and counter.
// RQ8 - Prescale select with source bit 0 sets divide ratio.
// RQ9 - Modulo accepts any value 0x00 through 0xff.
// RQ10 - Counter steps each prescaler period, wraps to 0x00 after modulo.
// RQ11 - Match flag sets as counter moves from modulo to 0x00.
// RQ12 - Any modulo write clears prescaler and counter.
// RQ13 - Interrupt raised while flag set and enable is one.
// RQ14 - Writing one to the flag clears flag and interrupt.
// RQ15 - Writing zero leaves the flag; reset clears it.
// RQ16 - Modulo zero sets flag on every prescaler output edge.
// RQ17 - Count is readable; writes to it do nothing.
// RQ18 - Source clocks synchronised into system domain; state read there.
`default_nettype none

module periodic_realtime_counter
	import rtc_pkg::*;
(
	// System
	input  wire logic              clk,
	input  wire logic              nrst,
	// Register port
	input  wire reg_req_t          req,
	output var  logic [DATA_W-1:0] rdata,
	// Source clocks
	input  wire src_clks_t         src,
	// Interrupt
	output var  logic              irq
);

	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************************************
	// Source clock edges
	// ****************************************************************
	logic lpo_rise;
	logic ext_rise;
	logic int_rise;

	// RQ18 source clock sync
	clock_edge_sync u_lpo (
		.clk  (clk),
		.nrst (nrst),
		.src  (src.low_power_osc_clock),
		.rise (lpo_rise)
	);

	clock_edge_sync u_ext (
		.clk  (clk),
		.nrst (nrst),
		.src  (src.external_ref_clock),
		.rise (ext_rise)
	);

	clock_edge_sync u_int (
		.clk  (clk),
		.nrst (nrst),
		.src  (src.internal_ref_clock),
		.rise (int_rise)
	);

	// ****************************************************************
	// Counter state
	// ****************************************************************
	// RQ1 counter and modulo
	rtc_state_t q;
	rtc_state_t d;

	logic              src_edge;
	logic [DIV_W-1:0]  div;
	logic              tick;
	logic              match_set;
	logic              match_clr;
	logic              restart;
	logic [CLKS_W-1:0] new_clks;
	logic [PS_W-1:0]   new_ps;

	always_comb begin
		d         = q;
		d.rdata   = RDATA_RST;
		tick      = 1'b0;
		match_set = 1'b0;
		match_clr = 1'b0;
		restart   = 1'b0;
		new_clks  = req.wdata[SC_CLKS_HI:SC_CLKS_LO];
		new_ps    = req.wdata[SC_PS_HI:SC_PS_LO];

		// RQ5 source select
		unique case (q.clock_source_select)
			CLKS_LPO: src_edge = lpo_rise;
			CLKS_EXT: src_edge = ext_rise;
			default:  src_edge = int_rise;
		endcase

		// RQ8 divide ratio
		div = DIV_TABLE[{q.clock_source_select[0], q.prescale_select}];

		// RQ4 prescaler gate
		if (q.prescale_select != PS_OFF && src_edge) begin
			if (q.presc == div - PRESC_ONE) begin
				d.presc = PRESC_RST;
				tick    = 1'b1;
			end else begin
				d.presc = q.presc + PRESC_ONE;
			end
		end

		// RQ10 count and wrap
		if (tick) begin
			if (q.count_value == q.modulo_value) begin
				d.count_value = CNT_RST;
				// RQ11 flag on wrap
				// RQ16 modulo zero every tick
				match_set = 1'b1;
			end else begin
				d.count_value = q.count_value + CNT_ONE;
			end
		end

		if (req.wr) begin
			unique case (req.addr)
				ADDR_SC: begin
					// RQ6 source change restart
					// RQ7 prescale change restart
					if (new_clks != q.clock_source_select ||
					    new_ps != q.prescale_select) begin
						restart = 1'b1;
					end
					d.clock_source_select = new_clks;
					d.prescale_select     = new_ps;
					d.match_irq_enable    = req.wdata[SC_IE_BIT];
					// RQ14 write one clears
					// RQ15 write zero keeps
					match_clr = req.wdata[SC_FLAG_BIT];
				end
				ADDR_MOD: begin
					// RQ9 full modulo range
					d.modulo_value = req.wdata;
					// RQ12 modulo write restart
					restart = 1'b1;
				end
				ADDR_IRQ_CLR: begin
					match_clr = req.wdata[IRQ_MATCH_BIT];
				end
				ADDR_IRQ_EN: begin
					d.match_irq_enable = req.wdata[IRQ_MATCH_BIT];
				end
				// RQ17 count writes ignored
				default: begin
				end
			endcase
		end

		if (restart) begin
			d.presc       = PRESC_RST;
			d.count_value = CNT_RST;
		end

		// A match in the same cycle as a clear wins, so no event is lost.
		d.match_flag = match_set | (q.match_flag & ~match_clr);

		if (req.rd) begin
			unique case (req.addr)
				ADDR_SC: begin
					d.rdata[SC_FLAG_BIT]           = q.match_flag;
					d.rdata[SC_CLKS_HI:SC_CLKS_LO] = q.clock_source_select;
					d.rdata[SC_IE_BIT]             = q.match_irq_enable;
					d.rdata[SC_PS_HI:SC_PS_LO]     = q.prescale_select;
				end
				// RQ17 count readable
				ADDR_CNT: d.rdata = q.count_value;
				ADDR_MOD: d.rdata = q.modulo_value;
				ADDR_IRQ_STAT: d.rdata[IRQ_MATCH_BIT] = q.match_flag;
				ADDR_IRQ_EN: d.rdata[IRQ_MATCH_BIT] = q.match_irq_enable;
				default: d.rdata = RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			// RQ2 reset state
			// RQ3 default source
			q.clock_source_select <= CLKS_LPO;
			q.prescale_select     <= PS_OFF;
			q.match_irq_enable    <= 1'b0;
			q.match_flag          <= 1'b0;
			q.modulo_value        <= MOD_RST;
			q.count_value         <= CNT_RST;
			q.presc               <= PRESC_RST;
			q.rdata               <= RDATA_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign rdata = q.rdata;

	// RQ13 enabled interrupt
	assign irq = q.match_flag & q.match_irq_enable;

endmodule

`default_nettype wire

// ---- rtc_sva.sv ----
// Checker for the register port and interrupt of the periodic counter.
// Assumes the source pins move slower than a quarter of clk.
`default_nettype none
module rtc_sva
	import rtc_pkg::*;
(
	// System
	input wire logic              clk,
	input wire logic              nrst,
	// Counter ports
	input wire reg_req_t          req,
	input wire logic [DATA_W-1:0] rdata,
	input wire src_clks_t         src,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// A tick lands within six cycles of a pin edge, so beyond eight
	// quiet cycles no flag can be set behind software's back.
	logic [3:0] quiet_q;
	src_clks_t  src_q;
	logic       quiet;
	always_ff @(posedge clk) begin
		src_q <= src;
		quiet_q <= (src != src_q || !nrst) ? 4'h0 :
			(quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
	end
	assign quiet = quiet_q > 4'h8;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	a_rdata_idle: assert property (
		!$past(req.rd) |-> rdata == RDATA_RST)
		else $error("read data outside the answer cycle");
	a_reset_quiet: assert property (
		$past(!nrst) |-> !irq && rdata == 8'h00)
		else $error("outputs busy right after reset");
	a_irq_rise: assert property (
		$rose(irq) |-> $past(req.wr) || !quiet)
		else $error("interrupt rose with no cause");
	a_irq_flag: assert property (
		req.rd && req.addr == ADDR_IRQ_STAT && irq
		|=> rdata[IRQ_MATCH_BIT])
		else $error("interrupt without status bit");
	a_irq_sc: assert property (
		req.rd && req.addr == ADDR_SC && irq
		|=> rdata[SC_FLAG_BIT] && rdata[SC_IE_BIT])
		else $error("interrupt without flag and enable");
	a_unmapped_zero: assert property (
		req.rd && req.addr > ADDR_IRQ_EN
		|=> rdata == RDATA_RST)
		else $error("unmapped read not zero");
	a_clr_drops: assert property (
		quiet && req.wr && req.wdata[IRQ_MATCH_BIT]
		&& req.addr == ADDR_IRQ_CLR |=> !irq)
		else $error("clear left the interrupt up");
	a_mod_restart: assert property (
		quiet && req.wr && req.addr == ADDR_MOD
		##[1:2] req.rd && req.addr == ADDR_CNT |=> rdata == CNT_RST)
		else $error("modulo write did not clear count");
	cover property ($rose(irq));
	cover property (req.wr && req.addr == ADDR_IRQ_CLR);
	cover property (req.rd && req.addr == ADDR_CNT ##1 rdata != 8'h00);
endmodule
bind periodic_realtime_counter rtc_sva chk_i (.clk(clk), .nrst(nrst),
	.req(req), .rdata(rdata), .src(src), .irq(irq));
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the periodic counter, via register calls, source pin pulses and direct irq checks.
// Assumes the checker is bound to the counter by its own file.
`default_nettype none
module testbench
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	reg_req_t          req = '0;
	src_clks_t         src = '0;
	logic [DATA_W-1:0] rdata;
	logic              irq;
	int                num_errors = 0;
	int                samples_checked = 0;
	int                cyc = 0;
	periodic_realtime_counter dut (.clk(clk), .nrst(nrst), .req(req),
		.rdata(rdata), .src(src), .irq(irq));
	initial begin
		forever #10 clk = ~clk;
	end
	task test_done;
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	task rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req.rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task irqc(input logic e);
		#1 chk({7'h00, irq}, {7'h00, e});
	endtask
	// Pin k pulses n times, eight cycles a period, then settles.
	task pulse(input int k, input int n);
		repeat (n) begin
			@(posedge clk);
			src <= src_clks_t'(3'h4 >> k);
			repeat (4) @(posedge clk);
			src <= '0;
			repeat (3) @(posedge clk);
		end
		repeat (12) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a < 8; a++)
			if (a != 4) rc(a[2:0], 8'h00);
		irqc(1'b0);
		pulse(0, 3);
		rc(ADDR_CNT, 8'h00);
		wr(ADDR_MOD, 8'hff);
		rc(ADDR_MOD, 8'hff);
		wr(ADDR_MOD, 8'h03);
		wr(ADDR_SC, 8'h08);
		pulse(0, 3);
		rc(ADDR_CNT, 8'h03);
		rc(ADDR_IRQ_STAT, 8'h00);
		pulse(0, 1);
		rc(ADDR_CNT, 8'h00);
		rc(ADDR_SC, 8'h88);
		irqc(1'b0);
		wr(ADDR_IRQ_EN, 8'h01);
		irqc(1'b1);
		wr(ADDR_CNT, 8'h55);
		rc(ADDR_CNT, 8'h00);
		wr(ADDR_SC, 8'h18);
		rc(ADDR_IRQ_STAT, 8'h01);
		wr(ADDR_IRQ_CLR, 8'h01);
		irqc(1'b0);
		pulse(0, 2);
		wr(ADDR_MOD, 8'h03);
		rc(ADDR_CNT, 8'h00);
		pulse(0, 2);
		wr(ADDR_SC, 8'h18);
		rc(ADDR_CNT, 8'h02);
		wr(ADDR_SC, 8'h19);
		rc(ADDR_CNT, 8'h00);
		pulse(0, 4);
		rc(ADDR_CNT, 8'h02);
		wr(ADDR_SC, 8'h59);
		rc(ADDR_CNT, 8'h00);
		pulse(0, 4);
		pulse(1, 4);
		rc(ADDR_CNT, 8'h00);
		pulse(2, 4);
		rc(ADDR_CNT, 8'h02);
		wr(ADDR_SC, 8'h38);
		pulse(1, 999);
		rc(ADDR_CNT, 8'h00);
		pulse(1, 1);
		rc(ADDR_CNT, 8'h01);
		wr(ADDR_SC, 8'h11);
		pulse(0, 7);
		rc(ADDR_CNT, 8'h00);
		pulse(0, 1);
		rc(ADDR_CNT, 8'h01);
		wr(ADDR_SC, 8'h78);
		pulse(2, 1000);
		rc(ADDR_CNT, 8'h01);
		wr(ADDR_MOD, 8'h00);
		wr(ADDR_SC, 8'h18);
		pulse(0, 1);
		rc(ADDR_SC, 8'h98);
		irqc(1'b1);
		wr(ADDR_SC, 8'h98);
		irqc(1'b0);
		pulse(0, 1);
		rc(ADDR_IRQ_STAT, 8'h01);
		rc(ADDR_CNT, 8'h00);
		wr(ADDR_SC, 8'h58);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rc(ADDR_SC, 8'h00);
		rc(ADDR_MOD, 8'h00);
		rc(ADDR_CNT, 8'h00);
		rc(ADDR_IRQ_STAT, 8'h00);
		irqc(1'b0);
		test_done;
	end
endmodule
`default_nettype wire
